// >>> caf_pkg.sv
/*
  caf_pkg: shared constants and carrier types for the channel alert status flags block.
  Assumes a single core clock, 16-bit conversion results, one result strobe per conversion.
*/
package caf_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CAF_OFS_FLAGS_CH4_7  = 8'h16;
  localparam logic [7:0] CAF_OFS_FLAGS_CH8_11 = 8'h17;
  localparam logic [7:0] CAF_OFS_IRQ_STATUS   = 8'h30;
  localparam logic [7:0] CAF_OFS_IRQ_MASK     = 8'h31;
  localparam logic [7:0] CAF_OFS_CONTROL      = 8'h32;
  localparam logic [7:0] CAF_FLAGS_RESET      = 8'h00;
  localparam logic [7:0] CAF_MASK_RESET       = 8'h00;
  localparam int         CAF_CTRL_ALERT_MODE  = 0;
  localparam int         CAF_IRQ_BANK_LO      = 0;
  localparam int         CAF_IRQ_BANK_HI      = 1;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int CAF_RESULT_W = 16;
  localparam int CAF_HYST_W   = 11;
  localparam int CAF_NCHAN    = 8;

  // per-channel threshold setup travelling together
  typedef struct packed {
    logic                    enable;
    logic [CAF_RESULT_W-1:0] lower;
    logic [CAF_RESULT_W-1:0] upper;
    logic [CAF_HYST_W-1:0]   clear_band_width;
  } caf_limits_t;

  // one conversion result and its channel
  typedef struct packed {
    logic                    valid;
    logic [3:0]              channel;
    logic [CAF_RESULT_W-1:0] result;
  } caf_conv_t;

endpackage

// >>> caf_chan_flags.sv
/*
  caf_chan_flags: lower and upper alert flags of one channel.
  Assumes the conversion strobe is one cycle and already matched to this channel.
*/
module caf_chan_flags
  import caf_pkg::*;
(
  input  wire logic                    i_clk,      // core clock
  input  wire logic                    i_rst_n,    // async reset, active low
  input  wire logic                    i_conv,     // result strobe for this channel
  input  wire logic [CAF_RESULT_W-1:0] i_result,   // conversion result
  input  wire caf_limits_t             i_limits,   // thresholds, enable, band
  input  wire logic                    i_mode,     // alert mode: band auto-clear
  input  wire logic                    i_rd_clr,   // register read clears
  output logic                         o_lo,       // below-limit flag
  output logic                         o_hi,       // above-limit flag
  output logic                         o_lo_set,   // lower set event
  output logic                         o_hi_set    // upper set event
);

  logic lo_q;
  logic hi_q;
  logic lo_band;
  logic hi_band;
  logic [CAF_RESULT_W:0] lo_edge;
  logic [CAF_RESULT_W:0] hi_edge;

  // band edges widened one bit so the sum cannot wrap and the difference keeps its borrow in the top bit
  assign lo_edge = {1'b0, i_limits.lower} + {{(CAF_RESULT_W+1-CAF_HYST_W){1'b0}},
                                             i_limits.clear_band_width};
  assign hi_edge = {1'b0, i_limits.upper} - {{(CAF_RESULT_W+1-CAF_HYST_W){1'b0}},
                                             i_limits.clear_band_width};

  // set events only with detection enabled
  assign o_lo_set = i_conv && i_limits.enable && (i_result <= i_limits.lower);
  assign o_hi_set = i_conv && i_limits.enable && (i_result >= i_limits.upper);

  // back inside the band: above lower+band, below upper-band
  assign lo_band = i_conv && i_mode && ({1'b0, i_result} > lo_edge);
  assign hi_band = i_conv && i_mode && (hi_edge[CAF_RESULT_W] ||
                                        ({1'b0, i_result} < hi_edge));

  // disabled channel keeps its flags inactive; set beats every clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_q <= 1'b0;
      hi_q <= 1'b0;
    end else if (!i_limits.enable) begin
      lo_q <= 1'b0;
      hi_q <= 1'b0;
    end else begin
      lo_q <= o_lo_set || (lo_q && !i_rd_clr && !lo_band);
      hi_q <= o_hi_set || (hi_q && !i_rd_clr && !hi_band);
    end
  end

  assign o_lo = lo_q;
  assign o_hi = hi_q;

endmodule // caf_chan_flags

// >>> caf_irq.sv
/*
  caf_irq: sticky event status, mask and one level interrupt.
  Assumes event pulses are one cycle; status clears by write-one.
*/
module caf_irq
  import caf_pkg::*;
#(
  parameter int N = 2
) (
  input  wire logic         i_clk,     // core clock
  input  wire logic         i_rst_n,   // async reset, active low
  input  wire logic [N-1:0] i_event,   // event pulses
  input  wire logic         i_wr_st,   // write strobe to status
  input  wire logic         i_wr_mk,   // write strobe to mask
  input  wire logic [N-1:0] i_wdata,   // write data
  output logic      [N-1:0] o_status,  // sticky status
  output logic      [N-1:0] o_mask,    // mask
  output logic              o_irq      // level interrupt
);

  logic [N-1:0] st_q;
  logic [N-1:0] mk_q;

  // new event wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= i_event | (st_q & ~(i_wr_st ? i_wdata : '0));
    end
  end

  // mask: one enables the matching status bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mk_q <= N'(CAF_MASK_RESET);
    end else if (i_wr_mk) begin
      mk_q <= i_wdata;
    end
  end

  assign o_status = st_q;
  assign o_mask   = mk_q;
  assign o_irq    = |(st_q & mk_q);

endmodule // caf_irq

// >>> caf_alert_flags.sv
/*
  caf_alert_flags: alert status registers for channels 4 to 11 with read-to-clear,
  clear_band_width auto-clear, and an interrupt on new flags.
  Assumes a plain register port (read data one cycle after the read strobe) and
  threshold setup held elsewhere and presented as steady inputs.
*/
module caf_alert_flags
  import caf_pkg::*;
#(
  parameter int FIRST_CH = 4
) (
  input  wire logic                  i_clk,       // core clock, 50 MHz
  input  wire logic                  i_rst_n,     // async reset, active low
  input  wire caf_conv_t             i_conv,      // conversion result strobe
  input  wire caf_limits_t [CAF_NCHAN-1:0] i_limits, // per channel setup, ch4 at 0
  input  wire logic [7:0]            i_addr,      // register address
  input  wire logic [7:0]            i_wdata,     // write data
  input  wire logic                  i_wr,        // write strobe
  input  wire logic                  i_rd,        // read strobe
  output logic      [7:0]            o_rdata,     // read data, cycle after read
  output logic                       o_irq        // interrupt level
);

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic       mode_q;
  logic [7:0] rdata_q;
  logic [CAF_NCHAN-1:0] lo;
  logic [CAF_NCHAN-1:0] hi;
  logic [CAF_NCHAN-1:0] lo_set;
  logic [CAF_NCHAN-1:0] hi_set;
  logic [15:0] flags;
  logic [1:0]  ist;
  logic [1:0]  imk;
  logic [1:0]  bank_ev;
  logic        rd_a;
  logic        rd_b;

  assign rd_a = i_rd && hit(i_addr, CAF_OFS_FLAGS_CH4_7);
  assign rd_b = i_rd && hit(i_addr, CAF_OFS_FLAGS_CH8_11);

  // ************************************************************
  // per channel flags
  // ************************************************************
  // reads clear a whole bank at once, as one register
  for (genvar c = 0; c < CAF_NCHAN; c++) begin : g_ch
    caf_chan_flags u_ch (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_conv   (i_conv.valid && (i_conv.channel == 4'(FIRST_CH + c))),
      .i_result (i_conv.result),
      .i_limits (i_limits[c]),
      .i_mode   (mode_q),
      .i_rd_clr ((c < 4) ? rd_a : rd_b),
      .o_lo     (lo[c]),
      .o_hi     (hi[c]),
      .o_lo_set (lo_set[c]),
      .o_hi_set (hi_set[c])
    );
    // lower flag on the odd bit of each pair
    assign flags[2*c+1] = lo[c];
    assign flags[2*c]   = hi[c];
  end

  // ************************************************************
  // control and interrupt
  // ************************************************************
  // alert mode selects band auto-clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 1'b0;
    end else if (i_wr && hit(i_addr, CAF_OFS_CONTROL)) begin
      mode_q <= i_wdata[CAF_CTRL_ALERT_MODE];
    end
  end

  assign bank_ev[CAF_IRQ_BANK_LO] = |(lo_set[3:0] | hi_set[3:0]);
  assign bank_ev[CAF_IRQ_BANK_HI] = |(lo_set[7:4] | hi_set[7:4]);

  caf_irq #(.N(2)) u_irq (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_event  (bank_ev),
    .i_wr_st  (i_wr && hit(i_addr, CAF_OFS_IRQ_STATUS)),
    .i_wr_mk  (i_wr && hit(i_addr, CAF_OFS_IRQ_MASK)),
    .i_wdata  (i_wdata[1:0]),
    .o_status (ist),
    .o_mask   (imk),
    .o_irq    (o_irq)
  );

  // ************************************************************
  // read port
  // ************************************************************
  // flag registers are read only; writes to them fall away. unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= CAF_FLAGS_RESET;
    end else if (i_rd) begin
      unique case (i_addr)
        CAF_OFS_FLAGS_CH4_7:  rdata_q <= flags[7:0];
        CAF_OFS_FLAGS_CH8_11: rdata_q <= flags[15:8];
        CAF_OFS_IRQ_STATUS:   rdata_q <= {6'h00, ist};
        CAF_OFS_IRQ_MASK:     rdata_q <= {6'h00, imk};
        CAF_OFS_CONTROL:      rdata_q <= {7'h00, mode_q};
        default:              rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;

endmodule // caf_alert_flags

// >>> caf_alert_flags_asserts.sv
/*
  caf_alert_flags_asserts: port-level checks of the alert flag banks.
  Assumes it is bound to caf_alert_flags and that the register master uses one-cycle strobes.
*/
module caf_alert_flags_asserts
  import caf_pkg::*;
#(
  parameter int FIRST_CH = 4
) (
  input wire logic                         i_clk,    // core clock
  input wire logic                         i_rst_n,  // async reset, active low
  input wire caf_conv_t                    i_conv,   // conversion strobe
  input wire caf_limits_t [CAF_NCHAN-1:0] i_limits, // channel setup
  input wire logic [7:0]                   i_addr,   // register address
  input wire logic [7:0]                   i_wdata,  // write data
  input wire logic                         i_wr,     // write strobe
  input wire logic                         i_rd,     // read strobe
  input wire logic [7:0]                   o_rdata,  // read data
  input wire logic                         o_irq     // interrupt level
);
  // ****
  // helpers
  // ****
  logic [7:0] en_q;                                  // detection enables, flattened
  wire        rd16  = i_rd && i_addr == CAF_OFS_FLAGS_CH4_7;
  wire        rd17  = i_rd && i_addr == CAF_OFS_FLAGS_CH8_11;
  wire  [3:0] conv_k = i_conv.channel - 4'(FIRST_CH); // channel index within the banks
  wire        quiet = !i_rd && !i_conv.valid;        // no read or conversion: nothing can set, only a dropped enable can clear
  always_comb begin
    for (int k = 0; k < 8; k++) en_q[k] = i_limits[k].enable;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // checks
  // ****
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  read_clear_a: assert property (
    rd16 && !i_conv.valid ##1 quiet ##1 rd16 |=> o_rdata == 8'h00)
    else $error("flags survived a read");
  lower_set_a: assert property (
    i_conv.valid && conv_k == 4'd1 && en_q[1] && i_conv.result <= i_limits[1].lower
    ##1 quiet && en_q[1] ##1 rd16 && en_q[1] |=> o_rdata[3]) else $error("lower flag missing");
  upper_set_a: assert property (
    i_conv.valid && conv_k == 4'd3 && en_q[3] && i_conv.result >= i_limits[3].upper
    ##1 quiet && en_q[3] ##1 rd16 && en_q[3] |=> o_rdata[6]) else $error("upper flag missing");
  bank_hi_a: assert property (
    i_conv.valid && conv_k == 4'd4 && en_q[4] && i_conv.result <= i_limits[4].lower
    ##1 quiet && en_q[4] ##1 rd17 && en_q[4] |=> o_rdata[1]) else $error("high bank flag missing");
  set_wins_a: assert property (
    rd16 && i_conv.valid && conv_k == 4'd0 && en_q[0] && i_conv.result <= i_limits[0].lower
    ##1 quiet && en_q[0] ##1 rd16 && en_q[0] |=> o_rdata[1]) else $error("read beat a set");
  disabled_a: assert property (
    rd16 && !en_q[1] && !$past(en_q[1]) |=> o_rdata[3:2] == 2'b00)
    else $error("flag of a disabled channel");
  mask_off_a: assert property (
    i_wr && i_addr == CAF_OFS_IRQ_MASK && i_wdata[1:0] == 2'b00 |=> !o_irq)
    else $error("interrupt while fully masked");
endmodule // caf_alert_flags_asserts

bind caf_alert_flags caf_alert_flags_asserts #(.FIRST_CH(FIRST_CH)) u_asserts (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv(i_conv), .i_limits(i_limits), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));

// >>> caf_alert_flags_tb.sv
/*
  caf_alert_flags_tb: register-level test of the alert flag banks.
  Assumes the checker binds itself; one 50 MHz clock, limits held as steady levels.
*/
module caf_alert_flags_tb
  import caf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus and tasks
  // ****
  logic                        i_clk = 1'b0;   // core clock
  logic                        i_rst_n = 1'b0; // reset, active low
  caf_conv_t                   conv = '0;
  caf_limits_t [CAF_NCHAN-1:0] lim;
  logic [7:0]                  addr = 8'h00;
  logic [7:0]                  wdata = 8'h00;
  logic                        wr = 1'b0;
  logic                        rd = 1'b0;
  logic [7:0]                  rdata;
  logic                        irq;
  int                          mismatches = 0;
  int                          check_count = 0;
  always #10 i_clk = ~i_clk;
  caf_alert_flags #(.FIRST_CH(4)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conv(conv), .i_limits(lim), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr    <= 1'b0;
    #1;
  endtask
  // read data is looked at only in the single cycle it stands
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic conv_at(input logic [3:0] ch, input logic [15:0] res);
    @(posedge i_clk);
    conv <= {1'b1, ch, res};
    @(posedge i_clk);
    conv.valid <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    for (int k = 0; k < CAF_NCHAN; k++) lim[k] <= {1'b1, 16'h0100, 16'hff00, 11'h010};
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_reg(8'h16, 8'h00);
    rd_reg(8'h17, 8'h00);
    rd_reg(8'h31, 8'h00);
    rd_reg(8'h45, 8'h00);
    chk({7'h00, irq}, 8'h00); // interrupt quiet after reset
    // every channel of both banks, each limit code and the code just inside it
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 4; k++) begin
        conv_at(4'(4 + 4 * b + k), 16'h0101);
        conv_at(4'(4 + 4 * b + k), 16'hfeff);
        rd_reg(8'h16 + 8'(b), 8'h00);
        conv_at(4'(4 + 4 * b + k), 16'h0100);
        rd_reg(8'h16 + 8'(b), 8'h02 << (2 * k));
        rd_reg(8'h16 + 8'(b), 8'h00);
        conv_at(4'(4 + 4 * b + k), 16'hff00);
        rd_reg(8'h16 + 8'(b), 8'h01 << (2 * k));
      end
    end
    // two flags at once; a write must neither set nor clear them
    conv_at(4'd4, 16'h0000);
    conv_at(4'd7, 16'hffff);
    wr_reg(8'h16, 8'hff);
    rd_reg(8'h16, 8'h42);
    // a disabled channel shows no flags, even one raised before
    conv_at(4'd5, 16'h0000);
    rd_reg(8'h17, 8'h00);
    // enable changes at a rising edge, like every other input
    @(posedge i_clk);
    lim[1].enable <= 1'b0;
    conv_at(4'd5, 16'h0000);
    rd_reg(8'h16, 8'h00);
    @(posedge i_clk);
    lim[1].enable <= 1'b1;
    // a set landing on the same edge as the read survives it
    conv_at(4'd4, 16'h0000);
    @(posedge i_clk);
    conv <= {1'b1, 4'd4, 16'h0000};
    addr <= 8'h16;
    rd   <= 1'b1;
    @(posedge i_clk);
    conv.valid <= 1'b0;
    rd <= 1'b0;
    #1;
    chk(rdata, 8'h02);
    rd_reg(8'h16, 8'h02);
    // band auto-clear only acts with alert mode on
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'h32, 8'(m));
      conv_at(4'd6, 16'h0050);
      conv_at(4'd6, 16'h0200);
      conv_at(4'd6, 16'hffff);
      conv_at(4'd6, 16'h8000);
      rd_reg(8'h16, (m == 1) ? 8'h00 : 8'h30);
    end
    rd_reg(8'h32, 8'h01);
    // interrupt: raise, mask, unmask, clear
    wr_reg(8'h30, 8'h03);
    wr_reg(8'h31, 8'h01);
    rd_reg(8'h31, 8'h01);
    conv_at(4'd9, 16'h0000);
    rd_reg(8'h30, 8'h02);
    chk({7'h00, irq}, 8'h00);
    conv_at(4'd4, 16'h0000);
    rd_reg(8'h30, 8'h03);
    chk({7'h00, irq}, 8'h01);
    wr_reg(8'h31, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h31, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr_reg(8'h30, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rd_reg(8'h30, 8'h02);
    tally_and_finish();
  end
endmodule // caf_alert_flags_tb
